//--- hw/odpr_pkg.sv
// Constants and types shared by the power-down / reference command decoder.
// Assumes a single 125 MHz system clock domain.
package odpr_pkg;

   localparam int          FRAME_BITS   = 32;
   localparam int          NUM_CH       = 8;
   localparam int          CODE_BITS    = 16;
   localparam int          AXI_AW       = 8;

   // Command codes
   localparam logic [3:0]  CMD_WR_UPD   = 4'h3;
   localparam logic [3:0]  CMD_PWR_DOWN = 4'h4;
   localparam logic [3:0]  CMD_REF_STAT = 4'h8;
   localparam logic [3:0]  CMD_REF_FLEX = 4'h9;
   localparam logic [3:0]  ADDR_ALL     = 4'hF;

   // Power-down field positions and modes
   localparam int          PD_MODE_LSB  = 8;
   localparam logic [1:0]  PD_UP        = 2'h0;
   localparam logic [1:0]  PD_1K        = 2'h1;
   localparam logic [1:0]  PD_100K      = 2'h2;
   localparam logic [1:0]  PD_HIZ       = 2'h3;

   // Flexible reference selector, frame bits 19..17
   localparam int          FLEX_SEL_LSB = 17;
   localparam logic [2:0]  FLEX_AUTO    = 3'h4;
   localparam logic [2:0]  FLEX_ON      = 3'h5;
   localparam logic [2:0]  FLEX_OFF     = 3'h6;
   localparam logic [2:0]  FLEX_STATIC  = 3'h0;

   // Register byte offsets
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_STATUS   = 8'h04;
   localparam logic [7:0]  OFF_PD       = 8'h08;
   localparam logic [7:0]  OFF_FRAME    = 8'h0C;
   localparam logic [7:0]  OFF_CMD      = 8'h10;
   localparam logic [7:0]  OFF_CODE_A   = 8'h14;

   localparam logic        CTRL_RST     = 1'h1;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef struct packed {
      logic        zero;
      logic [2:0]  dont_care;
      logic [3:0]  command_code_field;
      logic [3:0]  channel_address_field;
      logic [15:0] data;
      logic [3:0]  feature_bits_field;
   } odpr_frame_t;

   typedef enum logic [1:0] {
      REF_STATIC,
      REF_FLEX_AUTO,
      REF_FLEX_ON,
      REF_FLEX_OFF
   } odpr_ref_mode_t;

endpackage : odpr_pkg

//--- hw/odpr_rx.sv
// Serial frame receiver: samples the three-wire link with the system clock.
// Assumes the link clock is well below half the system clock rate.
`timescale 1ns/1ps
`default_nettype none
module odpr_rx #(
   parameter int FRAME_BITS = odpr_pkg::FRAME_BITS
) (
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                sclk_i,
   input  wire logic                sync_n_i,
   input  wire logic                din_i,
   output var  odpr_pkg::odpr_frame_t frame_o,
   output var  logic                frame_vld_o
);

   initial begin
      if (FRAME_BITS != $bits(odpr_pkg::odpr_frame_t)) begin
         $error("FRAME_BITS must match the frame layout");
      end
   end

   logic [2:0]            sclk_s_r;
   logic [1:0]            sync_s_r;
   logic [1:0]            din_s_r;
   logic [FRAME_BITS-1:0] shift_r;
   logic [5:0]            cnt_r;

   wire fall_w   = ~sclk_s_r[1] & sclk_s_r[2];
   wire active_w = ~sync_s_r[1];
   wire last_w   = (cnt_r == 6'(FRAME_BITS - 1));
   wire [FRAME_BITS-1:0] shift_nxt = {shift_r[FRAME_BITS-2:0], din_s_r[1]};

   // Two-stage synchronisers, third sclk stage for edge detection
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_s_r <= 3'h7;
         sync_s_r <= 2'h3;
         din_s_r  <= 2'h0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], sclk_i};
         sync_s_r <= {sync_s_r[0], sync_n_i};
         din_s_r  <= {din_s_r[0], din_i};
      end
   end

   // Bits taken on falling link edges; frame done on the 32nd
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_r     <= '0;
         cnt_r       <= 6'h00;
         frame_o     <= '0;
         frame_vld_o <= 1'b0;
      end else begin
         frame_vld_o <= 1'b0;
         if (!active_w) begin
            cnt_r <= 6'h00;
         end else if (fall_w) begin
            shift_r <= shift_nxt;
            if (last_w) begin
               cnt_r       <= 6'h00;
               frame_o     <= shift_nxt; // RQ1 RQ10
               frame_vld_o <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 6'h01;
            end
         end
      end
   end

endmodule : odpr_rx
`default_nettype wire

//--- hw/odpr_ctrl.sv
// Power-down, broadcast update and reference control decoder with AXI4-Lite view.
// Assumes link pins arrive asynchronously; one 125 MHz clock, async low reset.
// Operation
// RQ1: 32-bit frame, zero MSB, command, address
// RQ2: Mode 01 gives 1k termination
// RQ3: Bits 7..0 select channels A..H
// RQ4: Mode 10 gives 100k termination
// RQ5: Mode 11 gives high impedance
// RQ6: Unselected channels keep their mode
// RQ7: Flexible 101 keeps reference always on
// RQ8: Flexible 110 keeps reference always off
// RQ9: Code 3, address F writes all
// RQ10: Broadcast update lands at frame end
// RQ11: Reference starts disabled after power-up
// RQ12: Disabled reference leaves pin three-stated
// RQ13: Flexible commands carry bit 19 set
// RQ14: Static reference off until enabled
// RQ15: Static: all channels down, reference off
// RQ16: Static: any channel up, reference on
// RQ17: Reset returns static mode, reference off
// RQ18: Static command, feature bit 0 enables
// RQ19: Flexible 100 tracks channel power state
// RQ20: Flexible ignores static; 000 returns static
`timescale 1ns/1ps
`default_nettype none
module odpr_ctrl #(
   parameter int NUM_CH    = odpr_pkg::NUM_CH,
   parameter int CODE_BITS = odpr_pkg::CODE_BITS
) (
   input  wire logic                        CLK_I,
   input  wire logic                        RST_N_I,
   input  wire logic                        SCLK_I,
   input  wire logic                        SYNC_N_I,
   input  wire logic                        DIN_I,
   input  wire logic [odpr_pkg::AXI_AW-1:0] S_AXI_AWADDR,
   input  wire logic                        S_AXI_AWVALID,
   output var  logic                        S_AXI_AWREADY,
   input  wire logic [31:0]                 S_AXI_WDATA,
   input  wire logic [3:0]                  S_AXI_WSTRB,
   input  wire logic                        S_AXI_WVALID,
   output var  logic                        S_AXI_WREADY,
   output var  logic [1:0]                  S_AXI_BRESP,
   output var  logic                        S_AXI_BVALID,
   input  wire logic                        S_AXI_BREADY,
   input  wire logic [odpr_pkg::AXI_AW-1:0] S_AXI_ARADDR,
   input  wire logic                        S_AXI_ARVALID,
   output var  logic                        S_AXI_ARREADY,
   output var  logic [31:0]                 S_AXI_RDATA,
   output var  logic [1:0]                  S_AXI_RRESP,
   output var  logic                        S_AXI_RVALID,
   input  wire logic                        S_AXI_RREADY,
   output var  logic [2*NUM_CH-1:0]         CH_PD_MODE_O,
   output var  logic [NUM_CH*CODE_BITS-1:0] DAC_CODE_O,
   output var  logic                        DAC_UPDATE_O,
   output var  logic                        REF_PWR_O,
   output var  logic                        REF_PIN_OE_O
);

   initial begin
      if (NUM_CH != odpr_pkg::NUM_CH || CODE_BITS != odpr_pkg::CODE_BITS) begin
         $error("Channel count and code width are fixed by the frame layout");
      end
   end

   function automatic logic [5:0] word_of(input logic [odpr_pkg::AXI_AW-1:0] a);
      word_of = a[7:2];
   endfunction : word_of

   // ---------------- Link receiver
   odpr_pkg::odpr_frame_t rx_frame;
   logic                  rx_vld;

   odpr_rx #(
      .FRAME_BITS (odpr_pkg::FRAME_BITS)
   ) u_rx (
      .clk_i       (CLK_I),
      .rst_n_i     (RST_N_I),
      .sclk_i      (SCLK_I),
      .sync_n_i    (SYNC_N_I),
      .din_i       (DIN_I),
      .frame_o     (rx_frame),
      .frame_vld_o (rx_vld)
   );

   // ---------------- Register state
   logic                   rx_en_r;
   logic                   sw_pend_r;
   odpr_pkg::odpr_frame_t  sw_frame_r;
   odpr_pkg::odpr_frame_t  last_frame_r;
   logic [7:0]             frame_cnt_r;
   logic [7:0]             bad_cnt_r;
   logic [1:0]             pd_mode_r [NUM_CH];
   logic [CODE_BITS-1:0]   inbuf_r   [NUM_CH];
   logic                   static_en_r;
   odpr_pkg::odpr_ref_mode_t ref_mode_r;
   odpr_pkg::odpr_ref_mode_t ref_mode_nxt;
   logic                   static_en_nxt;

   // ---------------- AXI4-Lite slave
   logic                        aw_hold_r;
   logic                        w_hold_r;
   logic [odpr_pkg::AXI_AW-1:0] awaddr_r;
   logic [31:0]                 wdata_r;
   logic [3:0]                  wstrb_r;

   wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
   wire w_fire  = S_AXI_WVALID & S_AXI_WREADY;
   wire wr_do   = aw_hold_r & w_hold_r & ~S_AXI_BVALID;
   wire ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;

   wire [5:0] wr_word = word_of(awaddr_r);
   wire [5:0] rd_word = word_of(S_AXI_ARADDR);

   wire wr_ctrl = wr_do && (wr_word == word_of(odpr_pkg::OFF_CTRL));
   wire wr_cmd  = wr_do && (wr_word == word_of(odpr_pkg::OFF_CMD)) && (wstrb_r == 4'hF);
   wire wr_ok   = wr_ctrl || wr_cmd;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY  <= 1'b1;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= odpr_pkg::RESP_OKAY;
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
      end else begin
         if (aw_fire) begin
            aw_hold_r     <= 1'b1;
            S_AXI_AWREADY <= 1'b0;
         end
         if (w_fire) begin
            w_hold_r     <= 1'b1;
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_do) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_ok ? odpr_pkg::RESP_OKAY : odpr_pkg::RESP_SLVERR;
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID  <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         awaddr_r <= '0;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end else begin
         if (aw_fire) begin
            awaddr_r <= S_AXI_AWADDR;
         end
         if (w_fire) begin
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end
      end
   end

   // Read mux
   logic [31:0] rd_data;
   logic        rd_ok;
   logic [2*NUM_CH-1:0] pd_flat;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         pd_flat[2*i +: 2] = pd_mode_r[i];
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (rd_word == word_of(odpr_pkg::OFF_CTRL)) begin
         rd_data[0] = rx_en_r;
      end else if (rd_word == word_of(odpr_pkg::OFF_STATUS)) begin
         rd_data = {8'h00, bad_cnt_r, frame_cnt_r, 3'h0, sw_pend_r,
                    ref_mode_r, static_en_r, REF_PWR_O};
      end else if (rd_word == word_of(odpr_pkg::OFF_PD)) begin
         rd_data[2*NUM_CH-1:0] = pd_flat;
      end else if (rd_word == word_of(odpr_pkg::OFF_FRAME)) begin
         rd_data = last_frame_r;
      end else if (rd_word >= word_of(odpr_pkg::OFF_CODE_A) &&
                   rd_word <  word_of(odpr_pkg::OFF_CODE_A) + 6'(NUM_CH)) begin
         rd_data[CODE_BITS-1:0] =
            DAC_CODE_O[CODE_BITS*(rd_word - word_of(odpr_pkg::OFF_CODE_A)) +: CODE_BITS];
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= odpr_pkg::RESP_OKAY;
      end else if (ar_fire) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RDATA   <= rd_data;
         S_AXI_RRESP   <= rd_ok ? odpr_pkg::RESP_OKAY : odpr_pkg::RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID  <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // ---------------- Command source: link wins, software frame waits
   wire link_vld = rx_vld & rx_en_r;
   wire sw_take  = sw_pend_r & ~link_vld;
   wire cmd_vld  = link_vld | sw_take;
   odpr_pkg::odpr_frame_t cmd;
   assign cmd = link_vld ? rx_frame : sw_frame_r;

   wire cmd_good = cmd_vld & ~cmd.zero; // RQ1
   wire cmd_bad  = cmd_vld &  cmd.zero;
   wire is_pd    = cmd_good && (cmd.command_code_field == odpr_pkg::CMD_PWR_DOWN);
   wire is_wall  = cmd_good && (cmd.command_code_field == odpr_pkg::CMD_WR_UPD) &&
                   (cmd.channel_address_field == odpr_pkg::ADDR_ALL); // RQ9
   wire is_stat  = cmd_good && (cmd.command_code_field == odpr_pkg::CMD_REF_STAT);
   wire is_flex  = cmd_good && (cmd.command_code_field == odpr_pkg::CMD_REF_FLEX);

   wire [1:0]        pd_sel_mode = cmd[odpr_pkg::PD_MODE_LSB +: 2];
   wire [NUM_CH-1:0] pd_mask     = cmd[NUM_CH-1:0]; // RQ3
   wire [2:0]        flex_sel    = cmd[odpr_pkg::FLEX_SEL_LSB +: 3];

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rx_en_r    <= odpr_pkg::CTRL_RST;
         sw_pend_r  <= 1'b0;
         sw_frame_r <= '0;
      end else begin
         if (wr_ctrl && wstrb_r[0]) begin
            rx_en_r <= wdata_r[0];
         end
         if (wr_cmd) begin
            sw_pend_r  <= 1'b1;
            sw_frame_r <= wdata_r;
         end else if (sw_take) begin
            sw_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         last_frame_r <= '0;
         frame_cnt_r  <= 8'h00;
         bad_cnt_r    <= 8'h00;
      end else begin
         if (cmd_vld) begin
            last_frame_r <= cmd;
            frame_cnt_r  <= frame_cnt_r + 8'h01;
         end
         if (cmd_bad) begin
            bad_cnt_r <= bad_cnt_r + 8'h01;
         end
      end
   end

   // ---------------- Channel power-down
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int i = 0; i < NUM_CH; i++) begin
            pd_mode_r[i] <= odpr_pkg::PD_UP;
         end
      end else if (is_pd) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (pd_mask[i]) begin
               pd_mode_r[i] <= pd_sel_mode; // RQ2 RQ4 RQ5 RQ6
            end
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         CH_PD_MODE_O <= '0;
      end else begin
         CH_PD_MODE_O <= pd_flat;
      end
   end

   // ---------------- Broadcast write and update
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int i = 0; i < NUM_CH; i++) begin
            inbuf_r[i] <= '0;
         end
         DAC_CODE_O   <= '0;
         DAC_UPDATE_O <= 1'b0;
      end else begin
         DAC_UPDATE_O <= is_wall; // RQ10
         if (is_wall) begin
            for (int i = 0; i < NUM_CH; i++) begin
               inbuf_r[i]                         <= cmd.data;
               DAC_CODE_O[CODE_BITS*i +: CODE_BITS] <= cmd.data; // RQ9 RQ10
            end
         end
      end
   end

   // ---------------- Reference mode control
   always_comb begin
      ref_mode_nxt  = ref_mode_r;
      static_en_nxt = static_en_r;
      if (is_flex && cmd[odpr_pkg::FLEX_SEL_LSB + 2]) begin // RQ13
         case (flex_sel)
            odpr_pkg::FLEX_AUTO: ref_mode_nxt = odpr_pkg::REF_FLEX_AUTO; // RQ19
            odpr_pkg::FLEX_ON:   ref_mode_nxt = odpr_pkg::REF_FLEX_ON;   // RQ7
            odpr_pkg::FLEX_OFF:  ref_mode_nxt = odpr_pkg::REF_FLEX_OFF;  // RQ8
            default:             ref_mode_nxt = ref_mode_r;
         endcase
      end else if (is_flex && flex_sel == odpr_pkg::FLEX_STATIC) begin
         ref_mode_nxt  = odpr_pkg::REF_STATIC; // RQ20
         static_en_nxt = 1'b0;
      end else if (is_stat && ref_mode_r == odpr_pkg::REF_STATIC) begin
         static_en_nxt = cmd.feature_bits_field[0]; // RQ14 RQ18 RQ20
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ref_mode_r  <= odpr_pkg::REF_STATIC; // RQ11 RQ17
         static_en_r <= 1'b0;
      end else begin
         ref_mode_r  <= ref_mode_nxt;
         static_en_r <= static_en_nxt;
      end
   end

   // Any channel powered up keeps the tracking reference alive
   logic any_up;
   always_comb begin
      any_up = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         any_up = any_up | (pd_mode_r[i] == odpr_pkg::PD_UP);
      end
   end

   logic ref_pwr_nxt;
   always_comb begin
      case (ref_mode_r)
         odpr_pkg::REF_STATIC:    ref_pwr_nxt = static_en_r & any_up; // RQ14 RQ15 RQ16
         odpr_pkg::REF_FLEX_AUTO: ref_pwr_nxt = any_up;               // RQ19
         odpr_pkg::REF_FLEX_ON:   ref_pwr_nxt = 1'b1;                 // RQ7
         default:                 ref_pwr_nxt = 1'b0;                 // RQ8
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         REF_PWR_O    <= 1'b0; // RQ11
         REF_PIN_OE_O <= 1'b0;
      end else begin
         REF_PWR_O    <= ref_pwr_nxt;
         REF_PIN_OE_O <= ref_pwr_nxt; // RQ12
      end
   end

endmodule : odpr_ctrl
`default_nettype wire

//--- bench/odpr_host_model.sv
// Host model: sends one 32-bit frame on the three-wire link per request.
// Assumes frame_i stays steady while busy_o is high.
`timescale 1ns/1ps
`default_nettype none
module odpr_host_model #(
   parameter realtime HALF = 40.0
) (
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic [31:0] frame_i,
   output var  logic        busy_o,
   output var  logic        sclk_o,
   output var  logic        sync_n_o,
   output var  logic        din_o
);
   initial begin
      busy_o = 1'b0;
      sclk_o = 1'b1;
      sync_n_o = 1'b1;
      din_o = 1'b0;
      forever begin
         @(posedge clk_i iff go_i);
         #1.3 busy_o = 1'b1;
         sync_n_o = 1'b0;
         for (int i = 31; i >= 0; i--) begin
            din_o = frame_i[i];
            #HALF sclk_o = 1'b0;
            #HALF sclk_o = 1'b1;
         end
         #HALF sync_n_o = 1'b1;
         // Released line shows no stale bit
         din_o = ~din_o;
         #2.0 busy_o = 1'b0;
      end
   end
endmodule : odpr_host_model
`default_nettype wire

//--- bench/odpr_ctrl_monitor.sv
// Port checker for the command decoder.
// Assumes one clock domain; bound into odpr_ctrl below.
`timescale 1ns/1ps
`default_nettype none
module odpr_ctrl_monitor #(
   parameter int NUM_CH    = odpr_pkg::NUM_CH,
   parameter int CODE_BITS = odpr_pkg::CODE_BITS
) (
   input wire logic                        CLK_I,
   input wire logic                        RST_N_I,
   input wire logic                        S_AXI_AWVALID,
   input wire logic                        S_AXI_AWREADY,
   input wire logic                        S_AXI_WVALID,
   input wire logic                        S_AXI_WREADY,
   input wire logic [1:0]                  S_AXI_BRESP,
   input wire logic                        S_AXI_BVALID,
   input wire logic                        S_AXI_BREADY,
   input wire logic                        S_AXI_ARVALID,
   input wire logic                        S_AXI_ARREADY,
   input wire logic [31:0]                 S_AXI_RDATA,
   input wire logic                        S_AXI_RVALID,
   input wire logic                        S_AXI_RREADY,
   input wire logic [2*NUM_CH-1:0]         CH_PD_MODE_O,
   input wire logic [NUM_CH*CODE_BITS-1:0] DAC_CODE_O,
   input wire logic                        DAC_UPDATE_O,
   input wire logic                        REF_PWR_O,
   input wire logic                        REF_PIN_OE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence aw_w_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence upd_pulse;
      DAC_UPDATE_O ##1 !DAC_UPDATE_O;
   endsequence
   a_ref_pin_oe: assert property (REF_PIN_OE_O == REF_PWR_O)
      else $error("reference pin enable differs from reference power");
   a_upd_once: assert property (DAC_UPDATE_O |-> upd_pulse)
      else $error("update pulse longer than one cycle");
   a_code_with_upd: assert property (!$stable(DAC_CODE_O) |-> DAC_UPDATE_O)
      else $error("channel codes changed without update");
   a_reset_idle: assert property ($rose(RST_N_I) |->
      !REF_PWR_O && CH_PD_MODE_O == '0 && DAC_CODE_O == '0)
      else $error("outputs not at defaults after reset");
   a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped early");
   a_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("read answer not one cycle after address");
   a_b_answer: assert property (aw_w_taken |-> ##2 S_AXI_BVALID)
      else $error("write answer not two cycles after address and data");
endmodule : odpr_ctrl_monitor
bind odpr_ctrl odpr_ctrl_monitor #(.NUM_CH(NUM_CH), .CODE_BITS(CODE_BITS)) odpr_ctrl_monitor_i (
   .CLK_I, .RST_N_I, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
   .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
   .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .CH_PD_MODE_O, .DAC_CODE_O,
   .DAC_UPDATE_O, .REF_PWR_O, .REF_PIN_OE_O
);
`default_nettype wire

//--- bench/tb_octal_dac_powerdown_ref_ctrl.sv
// Testbench for the command decoder: link frames and AXI4-Lite accesses.
// Assumes the host model on the link; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
module tb_octal_dac_powerdown_ref_ctrl;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         go = 1'b0;
   logic [31:0]  frm = 32'h0;
   logic [7:0]   awa = 8'h0;
   logic [7:0]   ara = 8'h0;
   logic [31:0]  wd = 32'h0;
   logic         awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic         busy, sclk, sync_n, din, awr, wr, bv, arr, rv, upd, refp, refoe;
   logic [1:0]   br, rr, rm;
   logic [31:0]  rd;
   logic [15:0]  pdm, xcode;
   logic [127:0] code;
   logic [1:0]   md [8];
   logic         sen;
   logic [31:0]  seed = 32'h0DBDC5BD;
   int           num_errors = 0;
   int           num_checks = 0;
   logic [31:0]  dir [18] = '{32'h04000103, 32'h04000180, 32'h0400020C, 32'h04000220,
      32'h08000001, 32'h040003FF, 32'h04000004, 32'h08000000, 32'h09080000, 32'h040003FF,
      32'h04000001, 32'h090A0000, 32'h040003FF, 32'h08000001, 32'h090C0000, 32'h03F12340,
      32'h09000000, 32'h840001FF};

   always #4 clk = ~clk;

   odpr_host_model odpr_host_model_i (
      .clk_i(clk), .go_i(go), .frame_i(frm), .busy_o(busy),
      .sclk_o(sclk), .sync_n_o(sync_n), .din_o(din)
   );
   odpr_ctrl odpr_ctrl_i (
      .CLK_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk), .SYNC_N_I(sync_n), .DIN_I(din),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rre), .CH_PD_MODE_O(pdm), .DAC_CODE_O(code), .DAC_UPDATE_O(upd),
      .REF_PWR_O(refp), .REF_PIN_OE_O(refoe)
   );

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   function automatic logic xref();
      logic up;
      up = 1'b0;
      foreach (md[i]) up |= (md[i] == 2'h0);
      case (rm)
         2'h0: return sen & up;
         2'h1: return up;
         2'h2: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : xref

   function automatic logic [15:0] xpd();
      foreach (md[i]) xpd[2*i+:2] = md[i];
   endfunction : xpd

   task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic conclude();
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic model_reset();
      foreach (md[i]) md[i] = 2'h0;
      xcode = 16'h0;
      sen = 1'b0;
      rm = 2'h0;
   endtask : model_reset

   task automatic apply(input logic [31:0] f);
      if (!f[31]) begin
         case (f[27:24])
            4'h4: foreach (md[i]) if (f[i]) md[i] = f[9:8];
            4'h3: if (f[23:20] == 4'hF) xcode = f[19:4];
            4'h8: if (rm == 2'h0) sen = f[0];
            4'h9: case (f[19:17])
               3'h4: rm = 2'h1;
               3'h5: rm = 2'h2;
               3'h6: rm = 2'h3;
               3'h0: begin
                  rm = 2'h0;
                  sen = 1'b0;
               end
               default: ;
            endcase
            default: ;
         endcase
      end
   endtask : apply

   task automatic check_all();
      chk("pd_mode", xpd(), pdm);
      chk("ref_pwr", xref(), refp);
      chk("ref_oe", xref(), refoe);
      chk("codes", {8{xcode}}, code);
   endtask : check_all

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      rsp = br;
      chk("bvalid", 1'b1, bv);
      bre <= 1'b0;
      @(posedge clk);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      d = rd;
      rsp = rr;
      chk("rvalid", 1'b1, rv);
      rre <= 1'b0;
      @(posedge clk);
   endtask : axi_rd

   task automatic wait_busy(input logic lvl);
      for (int n = 0; n < 500 && busy !== lvl; n++) @(posedge clk);
      chk("host_busy", lvl, busy);
   endtask : wait_busy

   task automatic link(input logic [31:0] f);
      frm <= f;
      go <= 1'b1;
      wait_busy(1'b1);
      go <= 1'b0;
      wait_busy(1'b0);
   endtask : link

   task automatic send(input logic [31:0] f, input logic sw);
      logic [1:0] rsp;
      if (sw) begin
         axi_wr(odpr_pkg::OFF_CMD, f, rsp);
         chk("cmd_resp", odpr_pkg::RESP_OKAY, rsp);
      end else begin
         link(f);
      end
      repeat (10) @(posedge clk);
      apply(f);
      check_all();
   endtask : send

   initial begin
      logic [31:0] f, r, v;
      logic [1:0]  rsp;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      model_reset();
      repeat (2) @(posedge clk);
      check_all();
      axi_rd(odpr_pkg::OFF_CTRL, v, rsp);
      chk("ctrl_reset", 32'h1, v);
      axi_rd(8'hFC, v, rsp);
      chk("unmapped_rd", odpr_pkg::RESP_SLVERR, rsp);
      axi_wr(odpr_pkg::OFF_STATUS, 32'hFFFFFFFF, rsp);
      chk("ro_wr", odpr_pkg::RESP_SLVERR, rsp);
      foreach (dir[i]) send(dir[i], 1'b0);
      axi_wr(odpr_pkg::OFF_CTRL, 32'h0, rsp);
      link(32'h040000FF);
      check_all();
      axi_wr(odpr_pkg::OFF_CTRL, 32'h1, rsp);
      for (int k = 0; k < 40; k++) begin
         r = xs();
         case (r[1:0])
            2'h0: f = 32'h04000000 | (r & 32'h3FF);
            2'h1: f = 32'h03F00000 | (r & 32'hFFFF0);
            2'h2: f = 32'h08000000 | {31'h0, r[8]};
            default: f = (r[5:4] == 2'h0) ? 32'h09000000 : 32'h09000000 | ({29'h0, 3'h3 + {1'b0, r[5:4]}} << 17);
         endcase
         if (r[12:9] == 4'h0) f[31] = 1'b1;
         send(f, r[13]);
      end
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      model_reset();
      repeat (2) @(posedge clk);
      check_all();
      send(32'h08000001, 1'b0);
      conclude();
   end

   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      conclude();
   end
endmodule : tb_octal_dac_powerdown_ref_ctrl
`default_nettype wire
